// File: bench/ext_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model (
  // Clock
  input  wire logic        clk,
  // Bus from the controller
  input  wire logic [22:0] addr_o,
  input  wire logic [15:0] data_o,
  input  wire logic        data_oe,
  input  wire logic        memory_strobe_n,
  input  wire logic        io_strobe_n,
  input  wire logic        rw_n,
  // Answer to the controller
  input  var  int          stall,
  output logic      [15:0] data_i,
  output logic             ready
);
  logic [15:0] mem [16];
  logic [15:0] last_q;
  int          age;
  logic        act;
  assign act = !memory_strobe_n || !io_strobe_n;
  // Idle bus shows inverted last value, so stale data never matches
  assign data_i = (act && rw_n) ? mem[addr_o[3:0]] : ~last_q;
  // Slow device holds ready low for the first cycles of a strobe
  assign ready = !(act && age < stall);
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'ha5a0 ^ 16'(i * 16'h0111);
    end
    last_q = 16'h0000;
    age = 0;
  end
  always @(posedge clk) begin
    age <= act ? age + 1 : 0;
    last_q <= data_i;
    if (act && !rw_n && data_oe) begin
      mem[addr_o[3:0]] <= data_o;
    end
  end
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {
    logic [1:0] sp; logic wr; logic [22:0] ad; logic [15:0] wd;
    logic [2:0] ws; logic [3:0] st; logic [15:0] rd; logic lg;
  } row_t;
  logic clk, rst_n, req_valid, req_ready, req_write, rsp_valid, ready, hold_req_n;
  logic out_disable_n, addr_oe, data_oe, ctrl_oe, rw_n, bus_grant_ack_n, bus_grant_ack_oe;
  logic data_space_sel_n, program_space_sel_n, io_space_sel_n, memory_strobe_n, io_strobe_n;
  logic wait_states_done_n, wait_states_done_oe;
  logic [1:0]  req_space;
  logic [2:0]  req_wait_states;
  logic [22:0] req_addr, addr_o;
  logic [15:0] req_wdata, rsp_rdata, data_i, data_o;
  int          stall, fail_count, num_checks;
  logic [5:0]  pins;
  row_t rows [8] = '{
    '{2'h0, 1'h1, 23'h000003, 16'h1234, 3'h0, 4'h0, 16'h0000, 1'h0},
    '{2'h0, 1'h0, 23'h000003, 16'h0000, 3'h0, 4'h0, 16'h1234, 1'h0},
    '{2'h1, 1'h1, 23'h7f0005, 16'hbeef, 3'h1, 4'h0, 16'h0000, 1'h0},
    '{2'h1, 1'h0, 23'h000005, 16'h0000, 3'h2, 4'h0, 16'hbeef, 1'h0},
    '{2'h2, 1'h0, 23'h000009, 16'h0000, 3'h1, 4'h6, 16'hac39, 1'h0},
    '{2'h2, 1'h1, 23'h000002, 16'h0f0f, 3'h3, 4'h8, 16'h0000, 1'h1},
    '{2'h0, 1'h0, 23'h000002, 16'h0000, 3'h5, 4'h2, 16'h0f0f, 1'h0},
    '{2'h3, 1'h0, 23'h00000c, 16'h0000, 3'h0, 4'h0, 16'ha96c, 1'h0}};
  assign pins = {data_space_sel_n, program_space_sel_n, io_space_sel_n,
                 memory_strobe_n, io_strobe_n, rw_n};
  ext_bus_ctrl u_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_space(req_space), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_wait_states(req_wait_states),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ready(ready), .hold_req_n(hold_req_n),
    .out_disable_n(out_disable_n), .addr_o(addr_o), .addr_oe(addr_oe), .data_i(data_i),
    .data_o(data_o), .data_oe(data_oe), .data_space_sel_n(data_space_sel_n),
    .program_space_sel_n(program_space_sel_n), .io_space_sel_n(io_space_sel_n),
    .memory_strobe_n(memory_strobe_n), .io_strobe_n(io_strobe_n), .rw_n(rw_n),
    .ctrl_oe(ctrl_oe), .bus_grant_ack_n(bus_grant_ack_n), .bus_grant_ack_oe(bus_grant_ack_oe),
    .wait_states_done_n(wait_states_done_n), .wait_states_done_oe(wait_states_done_oe));
  ext_mem_model u_mem (.clk(clk), .addr_o(addr_o), .data_o(data_o), .data_oe(data_oe),
    .memory_strobe_n(memory_strobe_n), .io_strobe_n(io_strobe_n), .rw_n(rw_n),
    .stall(stall), .data_i(data_i), .ready(ready));
  task automatic give_verdict();
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    chk(32'(got), 32'(exp));
  endtask
  // Bounded wait for a pin to reach a level; a hang ends the run
  task automatic wait_pin(input int which, input logic v);
    int k;
    k = 0;
    while ((which == 0 ? bus_grant_ack_n : ctrl_oe) !== v) begin
      @(negedge clk);
      k++;
      if (k == 50) begin fail_count++; give_verdict(); end
    end
  endtask
  task automatic access(input row_t r);
    int n, w, e;
    @(negedge clk);
    stall = int'(r.st);
    req_space       = r.sp;
    req_write       = r.wr;
    req_addr        = r.ad;
    req_wdata       = r.wd;
    req_wait_states = r.ws;
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin @(negedge clk); n++; end
    if (n == 50) begin fail_count++; give_verdict(); end
    @(negedge clk);
    req_valid = 1'b0;
    chk(32'(pins), 32'({r.sp != 0, r.sp != 1, r.sp != 2, r.sp == 2, r.sp != 2, !r.wr}));
    chk(32'(addr_o), 32'(r.ad));
    chk(32'(data_oe), 32'(r.wr));
    n = 1;
    w = 0;
    while (rsp_valid !== 1'b1 && n < 60) begin
      if (wait_states_done_n === 1'b0) w++;
      @(negedge clk);
      n++;
    end
    if (n == 60) begin fail_count++; give_verdict(); end
    // Ready counts only from two wait states on, seen two clocks late
    e = int'(r.ws) + 2;
    if (r.ws >= 3'h2) begin
      e = (int'(r.st) + 4 > e + 1) ? int'(r.st) + 4 : e + 1;
    end
    if (!r.wr) chk(32'(rsp_rdata), 32'(r.rd));
    if (r.lg) chk_cnt(int'(n > r.ws + 2), 1);
    chk_cnt(n, e);
    chk_cnt(w, r.ws >= 2 ? r.ws - 1 : 0);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, req_valid, req_space, req_write, req_addr, req_wdata, req_wait_states} = '0;
    {hold_req_n, out_disable_n} = 2'h3;
    {stall, fail_count, num_checks} = '0;
    repeat (5) @(negedge clk);
    chk(32'({bus_grant_ack_n, bus_grant_ack_oe, pins}), 32'hff);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    foreach (rows[i]) access(rows[i]);
    // Hold arriving mid-access must wait for the access to finish
    fork
      access(rows[5]);
      begin repeat (3) @(negedge clk); hold_req_n = 1'b0; end
    join
    chk(32'(bus_grant_ack_n), 32'h1);
    wait_pin(0, 1'b0);
    chk(32'({addr_oe, data_oe, ctrl_oe, req_ready}), 32'h0);
    hold_req_n = 1'b1;
    wait_pin(0, 1'b1);
    wait_pin(1, 1'b1);
    out_disable_n = 1'b0;
    wait_pin(1, 1'b0);
    chk(32'({bus_grant_ack_oe, wait_states_done_oe}), 32'h0);
    out_disable_n = 1'b1;
    wait_pin(1, 1'b1);
    // Reset in mid-access drops every control back high at once
    @(negedge clk);
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    chk(32'(pins), 32'h34);
    rst_n = 1'b0;
    @(negedge clk);
    chk(32'({bus_grant_ack_n, bus_grant_ack_oe, pins}), 32'hff);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    access(rows[1]);
    give_verdict();
  end
endmodule
`default_nettype wire

// File: verilog/ext_bus_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Only the addressed space select goes low; others stay high.
// - Space select low exactly while the address is valid.
// - Space selects float in hold or when output disable is low.
// - Memory strobe low for every access outside I/O space, space code 3 included.
// - I/O strobe low only for I/O accesses.
// - Direction high except during a write.
// - Ready low stretches the access; retest each cycle until high.
// - Ready ignored unless at least two wait states programmed.
// - Ready sampled only after all wait states have elapsed.
// - Hold request floats address, data and control once acknowledged.
// - Acknowledge low only while in hold with lines floated.
// - Acknowledge floats when output disable is low.
// - Acknowledge high throughout reset.
// - Memory strobe floats in hold or when output disable is low.
// - Address lines float in hold; holders keep last level.
// - Data floats unless writing, and in reset or hold request.
// - Wait-done output low at first wait state, high at last, with at least two wait states programmed.
module ext_bus_ctrl (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  // Core request
  input  wire logic                            req_valid,
  output logic                                 req_ready,
  input  wire logic [1:0]                      req_space,
  input  wire logic                            req_write,
  input  wire logic [ext_bus_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [ext_bus_pkg::DATA_W-1:0]  req_wdata,
  input  wire logic [ext_bus_pkg::WS_W-1:0]    req_wait_states,
  output logic                                 rsp_valid,
  output logic      [ext_bus_pkg::DATA_W-1:0]  rsp_rdata,
  // Pins from outside
  input  wire logic                            ready,
  input  wire logic                            hold_req_n,
  input  wire logic                            out_disable_n,
  // Address and data bus
  output logic      [ext_bus_pkg::ADDR_W-1:0]  addr_o,
  output logic                                 addr_oe,
  input  wire logic [ext_bus_pkg::DATA_W-1:0]  data_i,
  output logic      [ext_bus_pkg::DATA_W-1:0]  data_o,
  output logic                                 data_oe,
  // Control pins
  output logic                                 data_space_sel_n,
  output logic                                 program_space_sel_n,
  output logic                                 io_space_sel_n,
  output logic                                 memory_strobe_n,
  output logic                                 io_strobe_n,
  output logic                                 rw_n,
  output logic                                 ctrl_oe,
  output logic                                 bus_grant_ack_n,
  output logic                                 bus_grant_ack_oe,
  output logic                                 wait_states_done_n,
  output logic                                 wait_states_done_oe
);
  typedef enum logic [1:0] {IDLE, WAITS, READY_WAIT, HOLD} state_t;

  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_sync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_q[1];

  logic [2:0] pins_s;
  sync2 #(.W(3)) u_sync (
    .clk     (clk),
    .rst_n   (rst_sync_n),
    .din     ({ready, ~hold_req_n, ~out_disable_n}),
    .rst_val (3'h0),
    .dout    (pins_s)
  );
  logic ready_s;
  logic hold_s;
  logic off_s;
  assign ready_s = pins_s[2];
  assign hold_s  = pins_s[1];
  assign off_s   = pins_s[0];

  // ----------------------------------------
  // Access and hold sequencer
  // ----------------------------------------
  state_t                           state_q, state_d;
  logic [ext_bus_pkg::WS_W-1:0]     ws_q, ws_d;
  logic [ext_bus_pkg::WS_W-1:0]     cnt_q, cnt_d;
  logic [1:0]                       space_q, space_d;
  logic                             write_q, write_d;
  logic [ext_bus_pkg::ADDR_W-1:0]   addr_q, addr_d;
  logic [ext_bus_pkg::DATA_W-1:0]   wdata_q, wdata_d;
  logic [ext_bus_pkg::DATA_W-1:0]   rdata_q, rdata_d;
  logic                             rsp_q, rsp_d;
  logic                             active;
  logic                             finish;

  function automatic logic ready_used(input logic [ext_bus_pkg::WS_W-1:0] ws);
    ready_used = (ws >= ext_bus_pkg::WS_W'(ext_bus_pkg::READY_MIN_WS));
  endfunction

  assign active    = (state_q == WAITS) || (state_q == READY_WAIT);
  assign req_ready = (state_q == IDLE) && !hold_s;

  always_comb begin
    state_d = state_q;
    ws_d    = ws_q;
    cnt_d   = cnt_q;
    space_d = space_q;
    write_d = write_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    rsp_d   = 1'b0;
    finish  = 1'b0;
    case (state_q)
      IDLE: begin
        if (hold_s) begin
          state_d = HOLD;
        end else if (req_valid) begin
          state_d = WAITS;
          ws_d    = req_wait_states;
          cnt_d   = '0;
          space_d = req_space;
          write_d = req_write;
          addr_d  = req_addr;
          wdata_d = req_wdata;
        end
      end
      WAITS: begin
        // One bus cycle plus the programmed wait states
        if (cnt_q == ws_q) begin
          if (ready_used(ws_q)) begin
            state_d = READY_WAIT;
          end else begin
            finish = 1'b1;
          end
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      READY_WAIT: begin
        // Ready low: wait a cycle and look again
        if (ready_s) begin
          finish = 1'b1;
        end
      end
      HOLD: begin
        if (!hold_s) begin
          state_d = IDLE;
        end
      end
      default: begin
        state_d = IDLE;
      end
    endcase
    if (finish) begin
      // Hold is only taken from idle, so the access always completes
      state_d = IDLE;
      rsp_d   = 1'b1;
      if (!write_q) begin
        rdata_d = data_i;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= IDLE;
      ws_q    <= '0;
      cnt_q   <= '0;
      space_q <= ext_bus_pkg::SPACE_DATA;
      write_q <= 1'b0;
      addr_q  <= ext_bus_pkg::ADDR_RESET;
      wdata_q <= ext_bus_pkg::DATA_RESET;
      rdata_q <= ext_bus_pkg::DATA_RESET;
      rsp_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      ws_q    <= ws_d;
      cnt_q   <= cnt_d;
      space_q <= space_d;
      write_q <= write_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      rsp_q   <= rsp_d;
    end
  end

  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  logic in_hold;
  assign in_hold = (state_q == HOLD);

  assign data_space_sel_n    = !(active && space_q == ext_bus_pkg::SPACE_DATA);
  assign program_space_sel_n = !(active && space_q == ext_bus_pkg::SPACE_PROG);
  assign io_space_sel_n      = !(active && space_q == ext_bus_pkg::SPACE_IO);
  assign memory_strobe_n     = !(active && space_q != ext_bus_pkg::SPACE_IO);
  assign io_strobe_n         = !(active && space_q == ext_bus_pkg::SPACE_IO);
  assign rw_n                = !(active && write_q);
  assign ctrl_oe             = !in_hold && !off_s;
  assign addr_o              = addr_q;
  assign addr_oe             = !in_hold && !off_s;
  assign data_o              = wdata_q;
  assign data_oe             = active && write_q && !hold_s && !off_s;
  assign bus_grant_ack_n     = !in_hold || !rst_sync_n;
  assign bus_grant_ack_oe    = !off_s;
  // Low from first wait state until the last one starts
  assign wait_states_done_n  = !(state_q == WAITS && ready_used(ws_q)
                                 && cnt_q >= 3'h1 && cnt_q < ws_q);
  assign wait_states_done_oe = !off_s;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  one_select_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (data_space_sel_n + program_space_sel_n + io_space_sel_n) >= 2'h2)
    else $error("more than one space select low");
  // The take edge loads a new address, so only later access cycles compare
  sel_addr_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (active && $past(active) && !(data_space_sel_n && program_space_sel_n
     && io_space_sel_n)) |-> $stable(addr_o))
    else $error("address moved under select");
  hold_float_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    in_hold |-> (!ctrl_oe && !addr_oe && !data_oe))
    else $error("bus driven in hold");
  off_float_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    off_s |-> (!ctrl_oe && !bus_grant_ack_oe && !addr_oe && !wait_states_done_oe))
    else $error("driven while output disabled");
  strobe_split_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !(!memory_strobe_n && !io_strobe_n))
    else $error("both strobes low");
  write_dir_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !rw_n |-> (active && write_q))
    else $error("direction low outside write");
  ready_skip_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (state_q == WAITS && cnt_q == ws_q && ws_q < 3'h2) |=> rsp_valid)
    else $error("short access did not finish");
  ready_stretch_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (state_q == READY_WAIT && !ready_s) |=> state_q == READY_WAIT)
    else $error("ready low did not stretch");
  grant_only_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !bus_grant_ack_n |-> ($past(hold_s) && !active))
    else $error("grant without hold");
  finish_first_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (active && hold_s) |=> !in_hold)
    else $error("hold taken mid access");
  reset_grant_a: assert property (@(posedge clk)
    !rst_sync_n |-> bus_grant_ack_n)
    else $error("grant low during reset");
  hold_strobe_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (in_hold || off_s) |-> !ctrl_oe)
    else $error("memory strobe driven in hold");
  data_float_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    data_oe |-> (active && write_q && !hold_s))
    else $error("data driven outside write");
  io_strobe_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !io_strobe_n |-> (active && space_q == ext_bus_pkg::SPACE_IO))
    else $error("io strobe outside io access");
  mem_strobe_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !memory_strobe_n |-> (active && space_q != ext_bus_pkg::SPACE_IO))
    else $error("memory strobe outside memory access");
  addr_float_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    in_hold |-> (!addr_oe && $stable(addr_o)))
    else $error("address driven or moved in hold");
  done_low_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (state_q == WAITS && ws_q >= 3'h2 && cnt_q == 3'h1) |-> !wait_states_done_n)
    else $error("wait done not low at first wait");
  done_high_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (state_q == WAITS && cnt_q == ws_q) |-> wait_states_done_n)
    else $error("wait done not high at last wait");
  ready_late_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (state_q == WAITS && cnt_q != ws_q) |=> state_q == WAITS)
    else $error("access left wait states early");
  ready_done_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (state_q == READY_WAIT && ready_s) |=> (rsp_valid && state_q == IDLE))
    else $error("ready high did not finish");
  grant_float_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !bus_grant_ack_n |-> (!addr_oe && !data_oe && !ctrl_oe))
    else $error("lines driven while granted");

  write_cov: cover property (@(posedge clk) disable iff (!rst_sync_n)
    active && write_q ##1 rsp_valid);
  ready_cov: cover property (@(posedge clk) disable iff (!rst_sync_n)
    state_q == READY_WAIT && !ready_s ##1 ready_s);
  hold_cov: cover property (@(posedge clk) disable iff (!rst_sync_n)
    !bus_grant_ack_n ##1 bus_grant_ack_n);
  off_cov: cover property (@(posedge clk) disable iff (!rst_sync_n)
    off_s ##1 !off_s);
  done_cov: cover property (@(posedge clk) disable iff (!rst_sync_n)
    !wait_states_done_n ##1 wait_states_done_n);
endmodule
`default_nettype wire

// File: verilog/ext_bus_pkg.sv
package ext_bus_pkg;
  // Space codes for a core request
  localparam logic [1:0] SPACE_DATA = 2'h0;
  localparam logic [1:0] SPACE_PROG = 2'h1;
  localparam logic [1:0] SPACE_IO   = 2'h2;
  // Widths, ready wait-state minimum and reset values
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int WS_W   = 3;
  localparam int READY_MIN_WS = 2;
  localparam logic [22:0] ADDR_RESET = 23'h000000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int READY_RETRY_NS = 10;
  localparam int READY_RETRY_CYC = (READY_RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// File: verilog/sync2.sv
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] din,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  always_comb begin
    meta_d = din ^ rst_val;
    out_d  = meta_q;
  end

  // Flops hold the offset from rst_val, so their reset stays a constant
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      out_q  <= '0;
    end else begin
      meta_q <= meta_d;
      out_q  <= out_d;
    end
  end

  assign dout = out_q ^ rst_val;
endmodule
`default_nettype wire
